// ===== rtl/exec_pkg.sv
package exec_pkg;

    // Data path and bus widths.
    localparam int DATA_W      = 8;
    localparam int BUS_W       = 16;
    localparam int ADDR_W      = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int FILE_WORDS  = 128;
    localparam int NIBBLE_W    = 4;
    localparam int OP_W        = 3;

    // Register map, byte addresses on the plain register port.
    localparam logic [ADDR_W-1:0] FILE_BASE_ADDR   = 8'h00;
    localparam logic [ADDR_W-1:0] FILE_LAST_ADDR   = 8'h7F;
    localparam logic [ADDR_W-1:0] ACCUM_ADDR       = 8'h80;
    localparam logic [ADDR_W-1:0] STATUS_ADDR      = 8'h81;
    localparam logic [ADDR_W-1:0] INSTR_ADDR       = 8'h82;
    localparam logic [ADDR_W-1:0] WATCHDOG_ADDR    = 8'h83;
    localparam logic [ADDR_W-1:0] PRESCALER_ADDR   = 8'h84;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR     = 8'h85;

    // Status register field positions.
    localparam int STAT_CARRY_BIT   = 0;
    localparam int STAT_NIBBLE_BIT  = 1;
    localparam int STAT_ZERO_BIT    = 2;
    localparam int STAT_PD_BIT      = 3;
    localparam int STAT_TO_BIT      = 4;
    localparam int STAT_SLEEP_BIT   = 5;

    // Control register field positions.
    localparam int CTRL_WAKE_BIT    = 0;

    // Instruction word layout.
    localparam int INSTR_OP_LSB     = 13;
    localparam int INSTR_DEST_BIT   = 12;

    // Opcodes.
    localparam logic [OP_W-1:0] OP_NOP        = 3'h0;
    localparam logic [OP_W-1:0] OP_ROTATE     = 3'h1;
    localparam logic [OP_W-1:0] OP_LIT_SUB    = 3'h2;
    localparam logic [OP_W-1:0] OP_FILE_SUB   = 3'h3;
    localparam logic [OP_W-1:0] OP_FILE_SUBB  = 3'h4;
    localparam logic [OP_W-1:0] OP_SLEEP      = 3'h5;

    // Reset and load values.
    localparam logic [DATA_W-1:0] BYTE_ZERO       = 8'h00;
    localparam logic [DATA_W-1:0] WATCHDOG_LOAD   = 8'h00;
    localparam logic [DATA_W-1:0] PRESCALER_CLEAR = 8'h00;
    localparam logic [DATA_W-1:0] PRESCALER_LAST  = 8'hFF;
    localparam logic [DATA_W-1:0] BYTE_ONE        = 8'h01;
    localparam logic [BUS_W-1:0]  BUS_ZERO        = 16'h0000;
    localparam logic              PD_RESET        = 1'b1;
    localparam logic              TO_RESET        = 1'b1;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_SLEEP = 2'b10
    } run_state_e;

    typedef struct packed {
        logic [OP_W-1:0]        op;
        logic                   dest;
        logic [DATA_W-1:0]      operand;
    } instr_s;

    typedef struct packed {
        logic [DATA_W-1:0]      result;
        logic                   carry;
        logic                   nibble_carry;
        logic                   zero;
    } alu_out_s;

    typedef struct packed {
        logic [ADDR_W-1:0]      addr;
        logic [BUS_W-1:0]       wdata;
        logic                   wr;
        logic                   rd;
    } bus_req_s;

endpackage : exec_pkg

// ===== rtl/sub_unit.sv
`timescale 1ns/1ps
`default_nettype none

module sub_unit
    import exec_pkg::*;
(
    // Operands.
    input  wire logic [DATA_W-1:0] minuend_in,
    input  wire logic [DATA_W-1:0] subtrahend_in,
    input  wire logic              carry_in,
    // Result and flags.
    output alu_out_s               alu_out
);

    logic [DATA_W:0]   full_sum;
    logic [NIBBLE_W:0] low_sum;

    // Subtraction is done as a plus the inverted b plus the carry, so a set carry means no borrow.
    always_comb begin
        full_sum = {1'b0, minuend_in} + {1'b0, ~subtrahend_in} + {{DATA_W{1'b0}}, carry_in};
        low_sum  = {1'b0, minuend_in[NIBBLE_W-1:0]} + {1'b0, ~subtrahend_in[NIBBLE_W-1:0]}
                 + {{NIBBLE_W{1'b0}}, carry_in};
        alu_out.result       = full_sum[DATA_W-1:0];
        alu_out.carry        = full_sum[DATA_W];
        alu_out.nibble_carry = low_sum[NIBBLE_W];
        alu_out.zero         = (full_sum[DATA_W-1:0] == BYTE_ZERO);
    end

endmodule : sub_unit

`default_nettype wire

// ===== rtl/subtract_rotate_sleep_exec.sv
// Function
// - Destination bit 0 writes accumulator, 1 writes addressed file register 0..127.
// - Rotate file register right through carry; only carry changes.
// - Literal minus accumulator into accumulator; carry and nibble carry mean no borrow.
// - File minus accumulator routed by destination; carry and nibble carry mean no borrow.
// - File minus accumulator minus inverted carry, routed by destination, updates three flags.
// - Sleep loads watchdog counter with zero and clears its prescaler.
// - Sleep clears the power-down status bit.
// - Sleep sets the time-out status bit.
// - Sleep halts execution with the oscillator stopped until woken.
`timescale 1ns/1ps
`default_nettype none

module subtract_rotate_sleep_exec
    import exec_pkg::*;
(
    // Clock and reset.
    input  wire logic              ref_clk_in,
    input  wire logic              rst_in,
    // Register port.
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [BUS_W-1:0]  wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [BUS_W-1:0]  rdata_out,
    // Wake and power state.
    input  wire logic              wake_in,
    output logic                   sleeping_out,
    output logic                   osc_run_out
);

    ////////////////////////////////////////////////////////////////////////////
    // State and helpers.

    typedef struct packed {
        logic [FILE_WORDS-1:0][DATA_W-1:0] file_mem;
        logic [DATA_W-1:0]                 accum;
        logic                              carry;
        logic                              nibble_carry;
        logic                              zero;
        logic                              powerdown_status_bit;
        logic                              timeout_status_bit;
        logic [DATA_W-1:0]                 watchdog_counter;
        logic [DATA_W-1:0]                 prescaler;
        run_state_e                        state;
        logic [BUS_W-1:0]                  rdata;
    } exec_state_s;

    exec_state_s state_reg;
    exec_state_s state_next;

    bus_req_s  bus_req;
    instr_s    instr;
    alu_out_s  alu_res;

    logic [DATA_W-1:0]      file_value;
    logic [DATA_W-1:0]      minuend;
    logic                   sub_carry;
    logic                   exec_strobe;
    logic                   wdog_tick;
    logic [FILE_ADDR_W-1:0] file_index;
    logic [DATA_W-1:0]      prescaler_run;
    logic [DATA_W-1:0]      watchdog_run;
    logic [BUS_W-1:0]       read_word;

    // File space decode serves the bus side only; the instruction side takes the index from file_idx with no range check.
    function automatic logic is_file_addr(input logic [ADDR_W-1:0] a);
        is_file_addr = (a >= FILE_BASE_ADDR) && (a <= FILE_LAST_ADDR);
    endfunction : is_file_addr

    function automatic logic [FILE_ADDR_W-1:0] file_idx(input logic [ADDR_W-1:0] a);
        file_idx = a[FILE_ADDR_W-1:0];
    endfunction : file_idx

    // Byte registers read back with the upper bus byte held at zero.
    function automatic logic [BUS_W-1:0] widen_byte(input logic [DATA_W-1:0] b);
        widen_byte = {{(BUS_W-DATA_W){1'b0}}, b};
    endfunction : widen_byte

    // Only the three flags are writable; the power bits and the sleep bit are read only.
    function automatic logic [BUS_W-1:0] status_word(input exec_state_s s);
        status_word                  = BUS_ZERO;
        status_word[STAT_CARRY_BIT]  = s.carry;
        status_word[STAT_NIBBLE_BIT] = s.nibble_carry;
        status_word[STAT_ZERO_BIT]   = s.zero;
        status_word[STAT_PD_BIT]     = s.powerdown_status_bit;
        status_word[STAT_TO_BIT]     = s.timeout_status_bit;
        status_word[STAT_SLEEP_BIT]  = (s.state == ST_SLEEP);
    endfunction : status_word

    // Bit 7 of the operand is dropped on file access, so the file space wraps at its last word.
    function automatic instr_s decode_instr(input logic [BUS_W-1:0] w);
        decode_instr.op      = w[INSTR_OP_LSB +: OP_W];
        decode_instr.dest    = w[INSTR_DEST_BIT];
        decode_instr.operand = w[DATA_W-1:0];
    endfunction : decode_instr

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection.

    always_comb begin
        bus_req.addr  = addr_in;
        bus_req.wdata = wdata_in;
        bus_req.wr    = wr_in;
        bus_req.rd    = rd_in;
        instr         = decode_instr(bus_req.wdata);
        file_index    = file_idx(instr.operand);
        file_value    = state_reg.file_mem[file_index];
        minuend       = (instr.op == OP_LIT_SUB) ? instr.operand : file_value;
        sub_carry     = (instr.op == OP_FILE_SUBB) ? state_reg.carry : 1'b1;
        exec_strobe   = bus_req.wr && (bus_req.addr == INSTR_ADDR) && (state_reg.state == ST_RUN);
        // The prescaler acts as the divider whose wrap is the watchdog enable pulse.
        wdog_tick     = (state_reg.state == ST_RUN) && (state_reg.prescaler == PRESCALER_LAST);
    end

    sub_unit u_sub (
        .minuend_in    (minuend),
        .subtrahend_in (state_reg.accum),
        .carry_in      (sub_carry),
        .alu_out       (alu_res)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog divider.

    // The prescaler wrap is the one-cycle enable for the watchdog counter.
    always_comb begin
        prescaler_run = state_reg.prescaler + BYTE_ONE;
        watchdog_run  = state_reg.watchdog_counter;
        if (wdog_tick) begin
            watchdog_run = state_reg.watchdog_counter + BYTE_ONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic [DATA_W-1:0] result;
        logic              write_back;
        result     = BYTE_ZERO;
        write_back = 1'b0;
        state_next = state_reg;
        state_next.rdata = BUS_ZERO;

        // The watchdog only counts while the oscillator runs.
        if (state_reg.state == ST_RUN) begin
            state_next.prescaler        = prescaler_run;
            state_next.watchdog_counter = watchdog_run;
        end

        // Register writes from software.
        if (bus_req.wr) begin
            if (is_file_addr(bus_req.addr)) begin
                state_next.file_mem[file_idx(bus_req.addr)] = bus_req.wdata[DATA_W-1:0];
            end
            case (bus_req.addr)
                ACCUM_ADDR: begin
                    state_next.accum = bus_req.wdata[DATA_W-1:0];
                end
                STATUS_ADDR: begin
                    state_next.carry        = bus_req.wdata[STAT_CARRY_BIT];
                    state_next.nibble_carry = bus_req.wdata[STAT_NIBBLE_BIT];
                    state_next.zero         = bus_req.wdata[STAT_ZERO_BIT];
                end
                CONTROL_ADDR: begin
                    if (bus_req.wdata[CTRL_WAKE_BIT] && (state_reg.state == ST_SLEEP)) begin
                        state_next.state = ST_RUN;
                    end
                end
                default: begin
                end
            endcase
        end

        // Instruction execution.
        if (exec_strobe) begin
            case (instr.op)
                OP_ROTATE: begin
                    result           = {state_reg.carry, file_value[DATA_W-1:1]};
                    state_next.carry = file_value[0];
                    write_back       = 1'b1;
                end
                OP_LIT_SUB: begin
                    state_next.accum        = alu_res.result;
                    state_next.carry        = alu_res.carry;
                    state_next.nibble_carry = alu_res.nibble_carry;
                    state_next.zero         = alu_res.zero;
                end
                OP_FILE_SUB, OP_FILE_SUBB: begin
                    result                  = alu_res.result;
                    write_back              = 1'b1;
                    state_next.carry        = alu_res.carry;
                    state_next.nibble_carry = alu_res.nibble_carry;
                    state_next.zero         = alu_res.zero;
                end
                OP_SLEEP: begin
                    state_next.watchdog_counter     = WATCHDOG_LOAD;
                    state_next.prescaler            = PRESCALER_CLEAR;
                    state_next.powerdown_status_bit = 1'b0;
                    state_next.timeout_status_bit   = 1'b1;
                    state_next.state                = ST_SLEEP;
                end
                default: begin
                end
            endcase
            if (write_back) begin
                if (instr.dest) begin
                    state_next.file_mem[file_index] = result;
                end else begin
                    state_next.accum = result;
                end
            end
        end

        // Waking by pin ends sleep; a wake while running does nothing.
        if (wake_in && (state_reg.state == ST_SLEEP)) begin
            state_next.state = ST_RUN;
        end

        // Read data shows the state before this edge, for one cycle only.
        if (bus_req.rd) begin
            state_next.rdata = read_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path.

    // Unmapped addresses read zero, so software never sees stale data there.
    always_comb begin
        read_word = BUS_ZERO;
        if (is_file_addr(bus_req.addr)) begin
            read_word = widen_byte(state_reg.file_mem[file_idx(bus_req.addr)]);
        end else begin
            case (bus_req.addr)
                ACCUM_ADDR: begin
                    read_word = widen_byte(state_reg.accum);
                end
                STATUS_ADDR: begin
                    read_word = status_word(state_reg);
                end
                WATCHDOG_ADDR: begin
                    read_word = widen_byte(state_reg.watchdog_counter);
                end
                PRESCALER_ADDR: begin
                    read_word = widen_byte(state_reg.prescaler);
                end
                default: begin
                    read_word = BUS_ZERO;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_reg.file_mem             <= '0;
            state_reg.accum                <= BYTE_ZERO;
            state_reg.carry                <= 1'b0;
            state_reg.nibble_carry         <= 1'b0;
            state_reg.zero                 <= 1'b0;
            state_reg.powerdown_status_bit <= PD_RESET;
            state_reg.timeout_status_bit   <= TO_RESET;
            state_reg.watchdog_counter     <= WATCHDOG_LOAD;
            state_reg.prescaler            <= PRESCALER_CLEAR;
            state_reg.state                <= ST_RUN;
            state_reg.rdata                <= BUS_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Gating the oscillator is left to the clock block, which watches this enable.
    always_comb begin
        rdata_out    = state_reg.rdata;
        sleeping_out = (state_reg.state == ST_SLEEP);
        osc_run_out  = (state_reg.state == ST_RUN);
    end

endmodule : subtract_rotate_sleep_exec

`default_nettype wire

// ===== testbench/subtract_rotate_sleep_exec_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module subtract_rotate_sleep_exec_chk
    import exec_pkg::*;
(
    // Clock and reset.
    input wire logic              ref_clk_in,
    input wire logic              rst_in,
    // Register port.
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [BUS_W-1:0]  wdata_in,
    input wire logic              wr_in,
    input wire logic              rd_in,
    input wire logic [BUS_W-1:0]  rdata_out,
    // Wake and power state.
    input wire logic              wake_in,
    input wire logic              sleeping_out,
    input wire logic              osc_run_out
);
    logic go_sleep;
    logic wake_wr;
    assign go_sleep = wr_in && addr_in == INSTR_ADDR && wdata_in[15:13] == OP_SLEEP;
    assign wake_wr  = wr_in && addr_in == CONTROL_ADDR && wdata_in[CTRL_WAKE_BIT];
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_osc_inverse: assert property (osc_run_out == !sleeping_out)
        else $error("oscillator enable not inverse of sleep state");
    a_sleep_entry: assert property (go_sleep && !sleeping_out |=> sleeping_out)
        else $error("sleep instruction did not halt");
    a_sleep_hold: assert property (sleeping_out && !wake_in && !wake_wr |=> sleeping_out)
        else $error("left sleep without a wake request");
    a_wake_exit: assert property (sleeping_out && (wake_in || wake_wr) |=> !sleeping_out)
        else $error("wake request ignored");
    a_sleep_status: assert property (rd_in && addr_in == STATUS_ADDR && sleeping_out
        |=> rdata_out[5:3] == 3'b110)
        else $error("power status bits wrong in sleep");
    a_watchdog_zero: assert property (rd_in && addr_in == WATCHDOG_ADDR && sleeping_out
        |=> rdata_out == BUS_ZERO)
        else $error("watchdog not zero in sleep");
    a_prescale_zero: assert property (rd_in && addr_in == PRESCALER_ADDR && sleeping_out
        |=> rdata_out == BUS_ZERO)
        else $error("prescaler not zero in sleep");
    a_read_idle: assert property (!rd_in |=> rdata_out == BUS_ZERO)
        else $error("read data outside read answer");
    a_unmapped_zero: assert property (rd_in && addr_in > CONTROL_ADDR |=> rdata_out == BUS_ZERO)
        else $error("unmapped read not zero");
    a_file_byte: assert property (rd_in && addr_in <= FILE_LAST_ADDR |=> rdata_out[15:8] == 8'h00)
        else $error("file read upper byte not zero");

    c_sleep: cover property (go_sleep && !sleeping_out);
    c_wake_pin: cover property (sleeping_out && wake_in);
    c_wake_reg: cover property (sleeping_out && wake_wr);
endmodule : subtract_rotate_sleep_exec_chk

bind subtract_rotate_sleep_exec subtract_rotate_sleep_exec_chk i_chk (
    .ref_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .wake_in, .sleeping_out, .osc_run_out
);

`default_nettype wire

// ===== testbench/wake_source.sv
`timescale 1ns/1ps
`default_nettype none

module wake_source #(
    parameter int DELAY = 5
) (
    // Clock and reset.
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // Request and device state.
    input  wire logic wake_req_in,
    input  wire logic sleeping_in,
    output logic      wake_out
);
    int count;

    // level wake source.
    // The level is held until the device leaves sleep, so a slow response is not lost.
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in || !sleeping_in) begin
            count    <= 0;
            wake_out <= 1'b0;
        end else if (wake_req_in) begin
            count    <= count + 1;
            wake_out <= (count >= DELAY);
        end
    end
endmodule : wake_source

`default_nettype wire

// ===== testbench/tb_subtract_rotate_sleep_exec.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, g); end end

module tb_subtract_rotate_sleep_exec;
    import exec_pkg::*;
    logic              ref_clk_in = 1'b0;
    logic              rst_in     = 1'b1;
    logic [ADDR_W-1:0] addr_in    = 8'h00;
    logic [BUS_W-1:0]  wdata_in   = 16'h0000;
    logic              wr_in      = 1'b0;
    logic              rd_in      = 1'b0;
    logic              wake_req   = 1'b0;
    logic              rd_reg     = 1'b0;
    logic [BUS_W-1:0]  rdata_out;
    logic [BUS_W-1:0]  exp_v;
    logic              wake_in;
    logic              sleeping_out;
    logic              osc_run_out;
    logic [7:0]        mem [FILE_WORDS];
    logic [7:0]        acc, a;
    logic [2:0]        op;
    logic              c, dc, z, pd, to, slp;
    logic [BUS_W-1:0]  exp_q [$];
    int                errors      = 0;
    int                comparisons = 0;

    subtract_rotate_sleep_exec i_dut (.ref_clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
        .rdata_out, .wake_in, .sleeping_out, .osc_run_out);
    wake_source i_wake (.ref_clk_in, .rst_in, .wake_req_in(wake_req), .sleeping_in(sleeping_out),
        .wake_out(wake_in));

    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    function automatic logic [15:0] stat();
        return {10'h000, slp, to, pd, z, dc, c};
    endfunction : stat

    task automatic bus_wr(input logic [7:0] ad, input logic [15:0] d);
        @(posedge ref_clk_in);
        addr_in  <= ad;
        wdata_in <= d;
        wr_in    <= 1'b1;
        @(posedge ref_clk_in);
        wr_in    <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] ad, input logic [15:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk_in);
        addr_in <= ad;
        rd_in   <= 1'b1;
        @(posedge ref_clk_in);
        rd_in   <= 1'b0;
    endtask : bus_rd

    task automatic put(input logic [7:0] ad, input logic [15:0] d);
        bus_wr(ad, d);
        if (ad <= FILE_LAST_ADDR) begin
            mem[ad[6:0]] = d[7:0];
        end
        if (ad == ACCUM_ADDR) begin
            acc = d[7:0];
        end
        if (ad == STATUS_ADDR) begin
            {z, dc, c} = d[2:0];
        end
    endtask : put

    // Carry is the inverted borrow, so the subtract adds the complement plus carry in.
    task automatic exec(input logic [2:0] o, input logic d, input logic [7:0] k);
        logic [7:0] f;
        logic [7:0] s;
        logic [8:0] r;
        logic [4:0] n;
        f = mem[k[6:0]];
        s = (o == OP_LIT_SUB) ? k : f;
        bus_wr(INSTR_ADDR, {o, d, 4'h0, k});
        if (o == OP_ROTATE) begin
            r = {f[0], c, f[7:1]};
        end else begin
            r = {1'b0, s} + {1'b0, ~acc} + ((o == OP_FILE_SUBB) ? c : 1'b1);
            n = {1'b0, s[3:0]} + {1'b0, ~acc[3:0]} + ((o == OP_FILE_SUBB) ? c : 1'b1);
            dc = n[4];
            z = (r[7:0] == 8'h00);
        end
        c = r[8];
        if (d && o != OP_LIT_SUB) begin
            mem[k[6:0]] = r[7:0];
        end else begin
            acc = r[7:0];
        end
        bus_rd(ACCUM_ADDR, {8'h00, acc});
        bus_rd({1'b0, k[6:0]}, {8'h00, mem[k[6:0]]});
        bus_rd(STATUS_ADDR, stat());
    endtask : exec

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk_in) begin
        rd_reg <= rd_in;
    end

    initial begin
        forever begin
            @(negedge ref_clk_in);
            if (rd_reg) begin
                exp_v = exp_q.pop_front();
                `CHK("rdata", exp_v, rdata_out)
            end
        end
    end

    initial begin
        #100000;
        errors++;
        $display("watchdog expired");
        test_done();
    end

    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        {acc, c, dc, z, slp, pd, to} = {8'h00, 6'b000011};
        void'($urandom(32'hD9E9CED0));
        repeat (16) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        bus_rd(STATUS_ADDR, stat());
        bus_rd(ACCUM_ADDR, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 48; i++) begin
            op = OP_ROTATE + 3'($urandom_range(3));
            a  = 8'($urandom);
            put(ACCUM_ADDR, 16'($urandom_range(255)));
            put({1'b0, a[6:0]}, (i % 4 == 0) ? {8'h00, acc} : 16'($urandom_range(255)));
            put(STATUS_ADDR, 16'($urandom_range(7)));
            if (op == OP_LIT_SUB && i % 4 == 0) begin
                a = acc;
            end
            exec(op, 1'($urandom), a);
        end
        bus_rd(8'($urandom_range(255, 134)), 16'h0000);
        bus_wr(INSTR_ADDR, {OP_NOP, 13'h1055});
        bus_wr(INSTR_ADDR, {3'h7, 13'h1055});
        bus_rd(ACCUM_ADDR, {8'h00, acc});
        bus_rd(8'h55, {8'h00, mem[7'h55]});
        bus_rd(STATUS_ADDR, stat());
        $display("test execute done");
        // Let the watchdog count so that the sleep load is seen.
        repeat (600) @(posedge ref_clk_in);
        bus_wr(INSTR_ADDR, {OP_SLEEP, 13'h0000});
        {slp, pd, to} = 3'b101;
        bus_rd(STATUS_ADDR, stat());
        bus_rd(WATCHDOG_ADDR, 16'h0000);
        bus_rd(PRESCALER_ADDR, 16'h0000);
        bus_wr(INSTR_ADDR, {OP_LIT_SUB, 13'h0055});
        bus_rd(ACCUM_ADDR, {8'h00, acc});
        `CHK("osc_run", 1'b0, osc_run_out)
        wake_req <= 1'b1;
        for (int k = 0; k < 50 && sleeping_out; k++) @(posedge ref_clk_in);
        wake_req <= 1'b0;
        slp = 1'b0;
        @(negedge ref_clk_in);
        `CHK("sleeping", 1'b0, sleeping_out)
        bus_rd(STATUS_ADDR, stat());
        exec(OP_LIT_SUB, 1'b0, 8'h3C);
        bus_wr(INSTR_ADDR, {OP_SLEEP, 13'h0000});
        @(negedge ref_clk_in);
        `CHK("sleeping", 1'b1, sleeping_out)
        bus_wr(CONTROL_ADDR, 16'h0001);
        @(negedge ref_clk_in);
        `CHK("sleeping", 1'b0, sleeping_out)
        $display("test sleep done");
        repeat (3) @(posedge ref_clk_in);
        test_done();
    end
endmodule : tb_subtract_rotate_sleep_exec

`default_nettype wire
